// ==== src/btcie_regs.svh ====
// Purpose: Constants of the bit, transfer and control executor
// Assumes: Included by bare name from design files
// Notes:   Status flag positions, pointer pair bases, port map, cycle counts
`ifndef BTCIE_REGS_SVH
`define BTCIE_REGS_SVH

// Status register flag positions
`define BTCIE_FLAG_C 3'h0
`define BTCIE_FLAG_Z 3'h1
`define BTCIE_FLAG_N 3'h2
`define BTCIE_FLAG_V 3'h3
`define BTCIE_FLAG_S 3'h4
`define BTCIE_FLAG_H 3'h5
`define BTCIE_FLAG_T 3'h6
`define BTCIE_FLAG_I 3'h7

// Low register of each pointer pair
`define BTCIE_PTR_X_BASE 5'h1a
`define BTCIE_PTR_Y_BASE 5'h1c
`define BTCIE_PTR_Z_BASE 5'h1e

// Software port map: 0x00..0x1f are the working registers
`define BTCIE_ADDR_STATUS 6'h20
`define BTCIE_ADDR_SP_LO  6'h21
`define BTCIE_ADDR_SP_HI  6'h22

`define BTCIE_STATUS_RST 8'h00

// Instruction lengths in clock cycles
`define BTCIE_CYC_ALU  2'h1
`define BTCIE_CYC_MEM  2'h2
`define BTCIE_CYC_PMEM 2'h3

`endif

// ==== src/btcie_pkg.sv ====
// Purpose: Types shared by the executor and its decoder
// Assumes: Nothing
// Notes:   Enumerations only; numeric constants live in btcie_regs.svh
package btcie_pkg;

  typedef enum logic [4:0] {
    no_op, rotate_right_carry_op, arith_shift_right_op, nibble_swap_op,
    flag_set_by_index_op, flag_clear_by_index_op,
    bit_to_transfer_flag_op, transfer_flag_to_bit_op,
    register_copy_op, register_pair_copy_op,
    indirect_load_op, displaced_load_op, direct_load_op,
    indirect_store_op, displaced_store_op, direct_store_op,
    program_memory_read_op, push_op, pop_op,
    sleep_op, watchdog_restart_op, break_op, other_op
  } btcie_op_t;

  typedef enum logic [1:0] {ptr_x, ptr_y, ptr_z} btcie_ptr_t;

  typedef enum logic [1:0] {addr_plain, addr_post_inc, addr_pre_dec, addr_disp} btcie_mode_t;

  typedef enum logic {ph_idle, ph_busy} btcie_phase_t;

endpackage

// ==== src/btcie_decode.sv ====
// Purpose: Opcode decoder for the bit, transfer and control instructions
// Assumes: One 16-bit instruction word presented at a time
// Notes:   Pure combinational; codes outside this group decode as other_op
`timescale 1ns/1ps
module btcie_decode import btcie_pkg::*; (
  // Instruction
  input  wire logic [15:0] instr_i,
  // Decoded fields
  output btcie_op_t        op_o,
  output logic      [4:0]  rd_o,
  output logic      [4:0]  rr_o,
  output logic      [2:0]  bit_o,
  output logic      [5:0]  q_o,
  output btcie_ptr_t       ptr_o,
  output btcie_mode_t      mode_o
);

  logic is_store;

  always_comb begin
    is_store = instr_i[9];
    op_o   = other_op;
    rd_o   = instr_i[8:4];
    rr_o   = {instr_i[9], instr_i[3:0]};
    bit_o  = instr_i[2:0];
    q_o    = {instr_i[13], instr_i[11:10], instr_i[2:0]};
    ptr_o  = ptr_z;
    mode_o = addr_plain;
    if (instr_i == 16'h0000) begin
      op_o = no_op;
    end else if (instr_i[15:10] == 6'h0b) begin
      op_o = register_copy_op;
    end else if (instr_i[15:8] == 8'h01) begin
      op_o = register_pair_copy_op;
      rd_o = {instr_i[7:4], 1'b0};
      rr_o = {instr_i[3:0], 1'b0};
    end else if (instr_i[15:14] == 2'h2 && !instr_i[12]) begin
      // Zero displacement is the plain Y or Z access
      op_o   = is_store ? displaced_store_op : displaced_load_op;
      ptr_o  = instr_i[3] ? ptr_y : ptr_z;
      mode_o = addr_disp;
    end else if (instr_i[15:10] == 6'h24) begin
      unique case (instr_i[3:0])
        4'h0: op_o = is_store ? direct_store_op : direct_load_op;
        4'h1, 4'h2, 4'h9, 4'ha, 4'hc, 4'hd, 4'he: begin
          op_o   = is_store ? indirect_store_op : indirect_load_op;
          ptr_o  = instr_i[3] ? (instr_i[2] ? ptr_x : ptr_y) : ptr_z;
          mode_o = (instr_i[1:0] == 2'h1) ? addr_post_inc :
                   (instr_i[1:0] == 2'h2) ? addr_pre_dec : addr_plain;
        end
        4'h4, 4'h5: begin
          if (!is_store) begin
            op_o   = program_memory_read_op;
            mode_o = instr_i[0] ? addr_post_inc : addr_plain;
          end
        end
        4'hf: op_o = is_store ? push_op : pop_op;
        default: op_o = other_op;
      endcase
    end else if (instr_i[15:9] == 7'h4a) begin
      unique case (instr_i[3:0])
        4'h7: op_o = rotate_right_carry_op;
        4'h5: op_o = arith_shift_right_op;
        4'h2: op_o = nibble_swap_op;
        4'h8: begin
          if (!instr_i[8]) begin
            op_o  = instr_i[7] ? flag_clear_by_index_op : flag_set_by_index_op;
            bit_o = instr_i[6:4];
          end else begin
            unique case (instr_i[7:4])
              4'h8: op_o = sleep_op;
              4'h9: op_o = break_op;
              4'ha: op_o = watchdog_restart_op;
              4'hc: begin
                op_o = program_memory_read_op;
                rd_o = 5'h00;
              end
              default: op_o = other_op;
            endcase
          end
        end
        default: op_o = other_op;
      endcase
    end else if (instr_i[15:10] == 6'h3e && !instr_i[3]) begin
      op_o = instr_i[9] ? bit_to_transfer_flag_op : transfer_flag_to_bit_op;
    end
  end

endmodule

// ==== src/btcie_exec.sv ====
// Purpose: Executes bit, flag, transfer, stack and core-control instructions
// Assumes: Memories answer a read strobe with data in the next cycle
// Notes:   Register file, status register and stack pointer are held here
// Notes on behaviour
// - Rotate right through carry: carry into bit 7, bit 0 to carry; Z,C,N,V,S.
// - Arithmetic shift right keeps bit 7; bit 0 to carry; Z,C,N,V,S; one cycle.
// - Nibble swap exchanges register halves, flags untouched, one cycle.
// - Flag set/clear alters only the indexed status flag in one cycle.
// - Bit store copies a register bit into the transfer flag, one cycle.
// - Bit load writes the transfer flag into a register bit, flags untouched.
// - Register and register-pair copies take one cycle, no flag change.
// - Indirect loads via X, Y, Z take two cycles; post-increment after read.
// - Pre-decrement load lowers pointer first, then reads at the new value.
// - Displaced load reads at Y or Z plus offset, pointer kept, two cycles.
// - Direct load reads the address carried by the instruction, two cycles.
// - Indirect stores plain, post-increment, pre-decrement; two cycles, no flags.
// - Displaced store writes at Y or Z plus offset, pointer kept, two cycles.
// - Direct store writes the instruction's address in two cycles.
// - Program memory read at Z takes three cycles; optional Z increment.
// - Push and pop use the stack, two cycles each, no flags.
// - No-op, sleep and watchdog restart take one cycle, flags untouched.
// - Breakpoint only signals the debug unit and leaves flags alone.
`timescale 1ns/1ps
`include "btcie_regs.svh"
module btcie_exec import btcie_pkg::*; #(
  parameter int          DAW     = 16,
  parameter logic [15:0] SP_INIT = 16'hffff
) (
  // Clock and reset
  input  wire logic           clk_i,
  input  wire logic           rst_n_i,
  // Instruction stream
  input  wire logic           instr_valid_i,
  input  wire logic [15:0]    instr_i,
  input  wire logic [15:0]    instr_k_i,
  output logic                instr_ready_o,
  // Data memory and stack
  output logic                dmem_re_o,
  output logic                dmem_we_o,
  output logic [DAW-1:0]      dmem_addr_o,
  output logic [7:0]          dmem_wdata_o,
  input  wire logic [7:0]     dmem_rdata_i,
  // Program memory
  output logic                pmem_re_o,
  output logic [15:0]         pmem_addr_o,
  input  wire logic [7:0]     pmem_rdata_i,
  // Software port
  input  wire logic [5:0]     bus_addr_i,
  input  wire logic [7:0]     bus_wdata_i,
  input  wire logic           bus_we_i,
  input  wire logic           bus_re_i,
  output logic [7:0]          bus_rdata_o,
  // Core control events
  output logic [7:0]          status_o,
  output logic                sleep_o,
  output logic                wdog_o,
  output logic                break_o,
  output logic                illegal_o
);

  typedef struct packed {
    logic [31:0][7:0] rf;
    logic [7:0]       status;
    logic [15:0]      sp;
    btcie_phase_t     phase;
    logic [1:0]       cnt;
    logic             wb_pend;
    logic             wb_pmem;
    logic [4:0]       wb_idx;
    logic [7:0]       rdata;
    logic             sleep;
    logic             wdog;
    logic             brk;
    logic             illegal;
  } btcie_state_t;

  btcie_state_t s_q;
  btcie_state_t s_d;

  btcie_op_t    dec_op;
  btcie_ptr_t   dec_ptr;
  btcie_mode_t  dec_mode;
  logic [4:0]   dec_rd;
  logic [4:0]   dec_rr;
  logic [2:0]   dec_bit;
  logic [5:0]   dec_q;

  logic [4:0]   pb;
  logic [15:0]  pv;
  logic [15:0]  ea;
  logic [15:0]  np;
  logic         ptr_wr;
  logic [7:0]   src;
  logic [7:0]   sh;
  logic         sh_c;
  logic         sh_n;
  logic         sh_v;
  logic         go;

  function automatic logic [4:0] ptr_base(input btcie_ptr_t p);
    unique case (p)
      ptr_x:   ptr_base = `BTCIE_PTR_X_BASE;
      ptr_y:   ptr_base = `BTCIE_PTR_Y_BASE;
      ptr_z:   ptr_base = `BTCIE_PTR_Z_BASE;
      default: ptr_base = `BTCIE_PTR_Z_BASE;
    endcase
  endfunction

  btcie_decode u_decode (
    .instr_i (instr_i),
    .op_o    (dec_op),
    .rd_o    (dec_rd),
    .rr_o    (dec_rr),
    .bit_o   (dec_bit),
    .q_o     (dec_q),
    .ptr_o   (dec_ptr),
    .mode_o  (dec_mode)
  );

  assign instr_ready_o = (s_q.phase == ph_idle);
  assign go            = instr_valid_i && instr_ready_o;
  assign src           = s_q.rf[dec_rd];

  // Effective address and pointer update for the pointer forms
  always_comb begin
    pb     = (dec_op == program_memory_read_op) ? `BTCIE_PTR_Z_BASE : ptr_base(dec_ptr);
    pv     = {s_q.rf[5'(pb + 5'h01)], s_q.rf[pb]};
    ea     = pv;
    np     = pv;
    ptr_wr = 1'b0;
    unique case (dec_mode)
      addr_post_inc: begin
        np     = pv + 16'h0001;
        ptr_wr = 1'b1;
      end
      addr_pre_dec: begin
        np     = pv - 16'h0001;
        ea     = np;
        ptr_wr = 1'b1;
      end
      addr_disp: ea = pv + {10'h000, dec_q};
      default: ea = pv;
    endcase
  end

  always_comb begin
    sh   = (dec_op == rotate_right_carry_op) ? {s_q.status[`BTCIE_FLAG_C], src[7:1]} : {src[7], src[7:1]};
    sh_c = src[0];
    sh_n = sh[7];
    sh_v = sh_n ^ sh_c;
  end

  always_comb begin
    s_d          = s_q;
    s_d.sleep    = 1'b0;
    s_d.wdog     = 1'b0;
    s_d.brk      = 1'b0;
    s_d.illegal  = 1'b0;
    s_d.rdata    = 8'h00;
    dmem_re_o    = 1'b0;
    dmem_we_o    = 1'b0;
    dmem_addr_o  = '0;
    dmem_wdata_o = 8'h00;
    pmem_re_o    = 1'b0;
    pmem_addr_o  = 16'h0000;

    // Software access; unmapped addresses read zero and ignore writes
    if (bus_re_i) begin
      if (!bus_addr_i[5]) begin
        s_d.rdata = s_q.rf[bus_addr_i[4:0]];
      end else if (bus_addr_i == `BTCIE_ADDR_STATUS) begin
        s_d.rdata = s_q.status;
      end else if (bus_addr_i == `BTCIE_ADDR_SP_LO) begin
        s_d.rdata = s_q.sp[7:0];
      end else if (bus_addr_i == `BTCIE_ADDR_SP_HI) begin
        s_d.rdata = s_q.sp[15:8];
      end
    end
    // Execution below overrides a software write to the same target
    if (bus_we_i) begin
      if (!bus_addr_i[5]) begin
        s_d.rf[bus_addr_i[4:0]] = bus_wdata_i;
      end else if (bus_addr_i == `BTCIE_ADDR_STATUS) begin
        s_d.status = bus_wdata_i;
      end else if (bus_addr_i == `BTCIE_ADDR_SP_LO) begin
        s_d.sp[7:0] = bus_wdata_i;
      end else if (bus_addr_i == `BTCIE_ADDR_SP_HI) begin
        s_d.sp[15:8] = bus_wdata_i;
      end
    end

    if (s_q.phase == ph_busy) begin
      // Memory data arrives in the first busy cycle
      if (s_q.wb_pend) begin
        s_d.rf[s_q.wb_idx] = s_q.wb_pmem ? pmem_rdata_i : dmem_rdata_i;
      end
      s_d.wb_pend = 1'b0;
      if (s_q.cnt == 2'h1) begin
        s_d.phase = ph_idle;
      end else begin
        s_d.cnt = s_q.cnt - 2'h1;
      end
    end else if (go) begin
      s_d.wb_idx  = dec_rd;
      s_d.wb_pmem = 1'b0;
      unique case (dec_op)
        rotate_right_carry_op, arith_shift_right_op: begin
          s_d.rf[dec_rd]              = sh;
          s_d.status[`BTCIE_FLAG_C]   = sh_c;
          s_d.status[`BTCIE_FLAG_Z]   = (sh == 8'h00);
          s_d.status[`BTCIE_FLAG_N]   = sh_n;
          s_d.status[`BTCIE_FLAG_V]   = sh_v;
          s_d.status[`BTCIE_FLAG_S]   = sh_n ^ sh_v;
        end
        nibble_swap_op: s_d.rf[dec_rd] = {src[3:0], src[7:4]};
        flag_set_by_index_op: s_d.status[dec_bit] = 1'b1;
        flag_clear_by_index_op: s_d.status[dec_bit] = 1'b0;
        bit_to_transfer_flag_op: s_d.status[`BTCIE_FLAG_T] = src[dec_bit];
        transfer_flag_to_bit_op: s_d.rf[dec_rd][dec_bit] = s_q.status[`BTCIE_FLAG_T];
        register_copy_op: s_d.rf[dec_rd] = s_q.rf[dec_rr];
        register_pair_copy_op: begin
          s_d.rf[dec_rd]               = s_q.rf[dec_rr];
          s_d.rf[5'(dec_rd + 5'h01)]   = s_q.rf[5'(dec_rr + 5'h01)];
        end
        indirect_load_op, displaced_load_op: begin
          dmem_re_o   = 1'b1;
          dmem_addr_o = DAW'(ea);
          if (ptr_wr) begin
            s_d.rf[pb]              = np[7:0];
            s_d.rf[5'(pb + 5'h01)]  = np[15:8];
          end
          s_d.wb_pend = 1'b1;
          s_d.cnt     = `BTCIE_CYC_MEM - 2'h1;
          s_d.phase   = ph_busy;
        end
        direct_load_op: begin
          dmem_re_o   = 1'b1;
          dmem_addr_o = DAW'(instr_k_i);
          s_d.wb_pend = 1'b1;
          s_d.cnt     = `BTCIE_CYC_MEM - 2'h1;
          s_d.phase   = ph_busy;
        end
        indirect_store_op, displaced_store_op: begin
          dmem_we_o    = 1'b1;
          dmem_addr_o  = DAW'(ea);
          dmem_wdata_o = src;
          if (ptr_wr) begin
            s_d.rf[pb]              = np[7:0];
            s_d.rf[5'(pb + 5'h01)]  = np[15:8];
          end
          s_d.cnt   = `BTCIE_CYC_MEM - 2'h1;
          s_d.phase = ph_busy;
        end
        direct_store_op: begin
          dmem_we_o    = 1'b1;
          dmem_addr_o  = DAW'(instr_k_i);
          dmem_wdata_o = src;
          s_d.cnt      = `BTCIE_CYC_MEM - 2'h1;
          s_d.phase    = ph_busy;
        end
        program_memory_read_op: begin
          pmem_re_o   = 1'b1;
          pmem_addr_o = pv;
          if (ptr_wr) begin
            s_d.rf[pb]              = np[7:0];
            s_d.rf[5'(pb + 5'h01)]  = np[15:8];
          end
          s_d.wb_pend = 1'b1;
          s_d.wb_pmem = 1'b1;
          s_d.cnt     = `BTCIE_CYC_PMEM - 2'h1;
          s_d.phase   = ph_busy;
        end
        push_op: begin
          dmem_we_o    = 1'b1;
          dmem_addr_o  = DAW'(s_q.sp);
          dmem_wdata_o = src;
          s_d.sp       = s_q.sp - 16'h0001;
          s_d.cnt      = `BTCIE_CYC_MEM - 2'h1;
          s_d.phase    = ph_busy;
        end
        pop_op: begin
          dmem_re_o   = 1'b1;
          dmem_addr_o = DAW'(s_q.sp + 16'h0001);
          s_d.sp      = s_q.sp + 16'h0001;
          s_d.wb_pend = 1'b1;
          s_d.cnt     = `BTCIE_CYC_MEM - 2'h1;
          s_d.phase   = ph_busy;
        end
        sleep_op: s_d.sleep = 1'b1;
        watchdog_restart_op: s_d.wdog = 1'b1;
        break_op: s_d.brk = 1'b1;
        no_op: s_d.illegal = 1'b0;
        // Codes of other groups retire in one cycle and pulse illegal_o
        default: s_d.illegal = 1'b1;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_q         <= '0;
      s_q.status  <= `BTCIE_STATUS_RST;
      s_q.sp      <= SP_INIT;
      s_q.phase   <= ph_idle;
      s_q.cnt     <= 2'h0;
    end else begin
      s_q <= s_d;
    end
  end

  assign bus_rdata_o = s_q.rdata;
  assign status_o    = s_q.status;
  assign sleep_o     = s_q.sleep;
  assign wdog_o      = s_q.wdog;
  assign break_o     = s_q.brk;
  assign illegal_o   = s_q.illegal;

endmodule

// ==== dv/btcie_exec_props.sv ====
// Purpose: Port level checks for the bit, transfer and control executor
// Assumes: Standard opcode layout on instr_i; no bus write in a take cycle
// Notes:   Register contents are not visible here, so flags, timing and the direct address only
`timescale 1ns/1ps
module btcie_exec_props #(
  parameter int DAW = 16
) (
  // Clock and reset
  input wire logic           clk_i,
  input wire logic           rst_n_i,
  // Instruction stream
  input wire logic           instr_valid_i,
  input wire logic [15:0]    instr_i,
  input wire logic [15:0]    instr_k_i,
  input wire logic           instr_ready_o,
  // Memories and events
  input wire logic           dmem_re_o,
  input wire logic           dmem_we_o,
  input wire logic [DAW-1:0] dmem_addr_o,
  input wire logic           pmem_re_o,
  input wire logic [7:0]     status_o,
  input wire logic           sleep_o
);
  logic       tk;
  logic [7:0] fb;
  assign tk = instr_valid_i && instr_ready_o;
  assign fb = 8'h01 << instr_i[6:4];

  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  a_mem_two_cyc: assert property (
    tk && (dmem_re_o || dmem_we_o) |=> !instr_ready_o ##1 instr_ready_o)
    else $error("data memory op length wrong");
  a_pmem_three_cyc: assert property (
    tk && pmem_re_o |=> !instr_ready_o [*2] ##1 instr_ready_o)
    else $error("program read length wrong");
  a_strobe_in_take: assert property (
    dmem_re_o || dmem_we_o || pmem_re_o |-> tk && !(dmem_re_o && dmem_we_o))
    else $error("strobe outside take cycle");
  a_swap_keeps_flags: assert property (
    tk && (instr_i & 16'hfe0f) == 16'h9402 |=> $stable(status_o) && instr_ready_o)
    else $error("nibble swap touched flags");
  a_flag_set_one: assert property (
    tk && (instr_i & 16'hff8f) == 16'h9408 |=> status_o == ($past(status_o) | $past(fb)))
    else $error("flag set wrong");
  a_flag_clr_one: assert property (
    tk && (instr_i & 16'hff8f) == 16'h9488 |=> status_o == ($past(status_o) & ~$past(fb)))
    else $error("flag clear wrong");
  a_bit_store_only: assert property (
    tk && (instr_i & 16'hfe08) == 16'hfa00 |=> ((status_o ^ $past(status_o)) & 8'hbf) == 8'h00)
    else $error("bit store changed other flags");
  a_direct_addr: assert property (
    tk && (instr_i & 16'hfc0f) == 16'h9000 |-> dmem_addr_o == instr_k_i[DAW-1:0])
    else $error("direct address wrong");
  a_sleep_pulse: assert property (
    tk && instr_i == 16'h9588 |=> sleep_o && instr_ready_o ##1 !sleep_o)
    else $error("sleep pulse wrong");
  a_move_one_cyc: assert property (
    tk && (instr_i & 16'hfc00) == 16'h2c00 |=> instr_ready_o && $stable(status_o))
    else $error("register copy wrong");
endmodule

bind btcie_exec btcie_exec_props #(.DAW(DAW)) btcie_exec_props_i (
  .clk_i         (clk_i),
  .rst_n_i       (rst_n_i),
  .instr_valid_i (instr_valid_i),
  .instr_i       (instr_i),
  .instr_k_i     (instr_k_i),
  .instr_ready_o (instr_ready_o),
  .dmem_re_o     (dmem_re_o),
  .dmem_we_o     (dmem_we_o),
  .dmem_addr_o   (dmem_addr_o),
  .pmem_re_o     (pmem_re_o),
  .status_o      (status_o),
  .sleep_o       (sleep_o)
);

// ==== dv/btcie_mem_model.sv ====
// Purpose: Data memory, stack and program memory beside the executor
// Assumes: Read data due one cycle after the strobe, no wait states
// Notes:   Latency is fixed by the port contract, so no slow mode exists
`timescale 1ns/1ps
module btcie_mem_model (
  // Clock
  input  wire logic        clk_i,
  // Data memory and stack
  input  wire logic        dmem_re_i,
  input  wire logic        dmem_we_i,
  input  wire logic [15:0] dmem_addr_i,
  input  wire logic [7:0]  dmem_wdata_i,
  output logic      [7:0]  dmem_rdata_o,
  // Program memory
  input  wire logic        pmem_re_i,
  input  wire logic [15:0] pmem_addr_i,
  output logic      [7:0]  pmem_rdata_o
);
  logic [7:0] mem [0:4095];
  initial begin
    for (int i = 0; i < 4096; i++) begin
      mem[i] = i[7:0] ^ {i[11:8], i[11:8]};
    end
    dmem_rdata_o = 8'h00;
    pmem_rdata_o = 8'h00;
  end
  // Data is inverted outside the answer cycle so a late sample cannot pass
  always @(posedge clk_i) begin
    dmem_rdata_o <= dmem_re_i ? mem[dmem_addr_i[11:0]] : ~dmem_rdata_o;
    pmem_rdata_o <= pmem_re_i ? (pmem_addr_i[7:0] ^ pmem_addr_i[15:8] ^ 8'ha5) : ~pmem_rdata_o;
    if (dmem_we_i) begin
      mem[dmem_addr_i[11:0]] <= dmem_wdata_i;
    end
  end
endmodule

// ==== dv/btcie_exec_tb.sv ====
// Purpose: Self-checking bench for the executor
// Assumes: Registers are set and read through the software port
// Notes:   One idle cycle between requests keeps the driver simple
`timescale 1ns/1ps
`include "btcie_regs.svh"
module btcie_exec_tb;
  logic        clk_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic        instr_valid_i = 1'b0;
  logic        bus_we_i = 1'b0;
  logic        bus_re_i = 1'b0;
  logic [15:0] instr_i = 16'h0000;
  logic [15:0] instr_k_i = 16'h0000;
  logic [5:0]  bus_addr_i = 6'h00;
  logic [7:0]  bus_wdata_i = 8'h00;
  logic        instr_ready_o, dmem_re_o, dmem_we_o, pmem_re_o;
  logic        sleep_o, wdog_o, break_o, illegal_o;
  logic [3:0]  ev = 4'h0;
  logic [15:0] dmem_addr_o, pmem_addr_o;
  logic [7:0]  dmem_wdata_o, dmem_rdata_i, pmem_rdata_i, bus_rdata_o, status_o;
  int          num_errors = 0;
  int          num_checks = 0;
  int          cycle_count = 0;

  // Stack start fixed here so the stack checks do not lean on the design default
  btcie_exec #(
    .SP_INIT (16'hffff)
  ) btcie_exec_i (
    .clk_i         (clk_i),
    .rst_n_i       (rst_n_i),
    .instr_valid_i (instr_valid_i),
    .instr_i       (instr_i),
    .instr_k_i     (instr_k_i),
    .instr_ready_o (instr_ready_o),
    .dmem_re_o     (dmem_re_o),
    .dmem_we_o     (dmem_we_o),
    .dmem_addr_o   (dmem_addr_o),
    .dmem_wdata_o  (dmem_wdata_o),
    .dmem_rdata_i  (dmem_rdata_i),
    .pmem_re_o     (pmem_re_o),
    .pmem_addr_o   (pmem_addr_o),
    .pmem_rdata_i  (pmem_rdata_i),
    .bus_addr_i    (bus_addr_i),
    .bus_wdata_i   (bus_wdata_i),
    .bus_we_i      (bus_we_i),
    .bus_re_i      (bus_re_i),
    .bus_rdata_o   (bus_rdata_o),
    .status_o      (status_o),
    .sleep_o       (sleep_o),
    .wdog_o        (wdog_o),
    .break_o       (break_o),
    .illegal_o     (illegal_o)
  );
  btcie_mem_model btcie_mem_model_i (
    .clk_i        (clk_i),
    .dmem_re_i    (dmem_re_o),
    .dmem_we_i    (dmem_we_o),
    .dmem_addr_i  (dmem_addr_o),
    .dmem_wdata_i (dmem_wdata_o),
    .dmem_rdata_o (dmem_rdata_i),
    .pmem_re_i    (pmem_re_o),
    .pmem_addr_i  (pmem_addr_o),
    .pmem_rdata_o (pmem_rdata_i)
  );

  always #2.5 clk_i = ~clk_i;

  function automatic logic [7:0] mv(input logic [15:0] a);
    return a[7:0] ^ {a[11:8], a[11:8]};
  endfunction

  task automatic final_report;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic bw(input logic [5:0] a, input logic [7:0] d);
    @(posedge clk_i);
    bus_addr_i  <= a;
    bus_wdata_i <= d;
    bus_we_i    <= 1'b1;
    @(posedge clk_i);
    bus_we_i <= 1'b0;
  endtask

  task automatic br(input logic [5:0] a, input logic [7:0] e);
    @(posedge clk_i);
    bus_addr_i <= a;
    bus_re_i   <= 1'b1;
    @(posedge clk_i);
    bus_re_i <= 1'b0;
    #1;
    check({8'h00, bus_rdata_o}, {8'h00, e});
  endtask

  task automatic mc(input logic [11:0] a, input logic [7:0] e);
    check({8'h00, btcie_mem_model_i.mem[a]}, {8'h00, e});
  endtask

  // Count of 0 means the length is not defined and is not compared
  task automatic ex(input logic [15:0] w, input logic [15:0] k, input logic [15:0] n);
    logic [15:0] c;
    c = 16'h0001;
    @(posedge clk_i);
    instr_i       <= w;
    instr_k_i     <= k;
    instr_valid_i <= 1'b1;
    @(posedge clk_i);
    instr_valid_i <= 1'b0;
    #1;
    // Event pulses stand only in the cycle after the take
    ev = {sleep_o, wdog_o, break_o, illegal_o};
    while (instr_ready_o !== 1'b1 && c < 16'h0008) begin
      @(posedge clk_i);
      #1;
      c++;
    end
    if (n != 16'h0000) begin
      check(c, n);
    end
  endtask

  always @(posedge clk_i) begin
    cycle_count++;
    if (cycle_count == 5000) begin
      num_errors++;
      final_report();
    end
  end

  initial begin
    logic [7:0] e;
    e = 8'h00;
    repeat (12) @(posedge clk_i);
    rst_n_i <= 1'b1;
    br(`BTCIE_ADDR_STATUS, `BTCIE_STATUS_RST);
    bw(6'h3f, 8'h5a);
    br(6'h3f, 8'h00);
    bw(6'h10, 8'h81);
    bw(`BTCIE_ADDR_STATUS, 8'hc1);
    ex(16'h9507, 16'h0000, 16'h0001);
    br(6'h10, 8'hc0);
    br(`BTCIE_ADDR_STATUS, 8'hd5);
    bw(6'h11, 8'h80);
    bw(`BTCIE_ADDR_STATUS, 8'h20);
    ex(16'h9515, 16'h0000, 16'h0001);
    br(6'h11, 8'hc0);
    br(`BTCIE_ADDR_STATUS, 8'h2c);
    bw(6'h12, 8'h3c);
    ex(16'h9522, 16'h0000, 16'h0001);
    br(6'h12, 8'hc3);
    br(`BTCIE_ADDR_STATUS, 8'h2c);
    bw(`BTCIE_ADDR_STATUS, 8'h00);
    for (int i = 0; i < 16; i++) begin
      e[i[2:0]] = ~i[3];
      ex({8'h94, i[3], i[2:0], 4'h8}, 16'h0000, 16'h0001);
      br(`BTCIE_ADDR_STATUS, e);
    end
    bw(6'h13, 8'h04);
    ex(16'hfb32, 16'h0000, 16'h0001);
    br(`BTCIE_ADDR_STATUS, 8'h40);
    ex(16'hf947, 16'h0000, 16'h0001);
    br(6'h14, 8'h80);
    ex(16'h2f54, 16'h0000, 16'h0001);
    br(6'h15, 8'h80);
    ex(16'h0119, 16'h0000, 16'h0001);
    br(6'h02, 8'hc3);
    br(6'h03, 8'h04);
    br(`BTCIE_ADDR_STATUS, 8'h40);
    // Pointer steps cross a byte boundary both ways
    bw(6'h1a, 8'h00);
    bw(6'h1b, 8'h02);
    ex(16'h901e, 16'h0000, 16'h0002);
    br(6'h01, mv(16'h01ff));
    br(6'h1b, 8'h01);
    ex(16'h900d, 16'h0000, 16'h0002);
    br(6'h00, mv(16'h01ff));
    br(6'h1b, 8'h02);
    bw(6'h1c, 8'h00);
    bw(6'h1d, 8'h03);
    ex(16'hac4f, 16'h0000, 16'h0002);
    br(6'h04, mv(16'h033f));
    br(6'h1c, 8'h00);
    bw(6'h1e, 8'h10);
    bw(6'h1f, 8'h04);
    ex(16'h8050, 16'h0000, 16'h0002);
    br(6'h05, mv(16'h0410));
    ex(16'h9060, 16'h0abc, 16'h0002);
    br(6'h06, mv(16'h0abc));
    ex(16'h935d, 16'h0000, 16'h0002);
    mc(12'h200, 8'h80);
    br(6'h1a, 8'h01);
    ex(16'h922a, 16'h0000, 16'h0002);
    mc(12'h2ff, 8'hc3);
    br(6'h1d, 8'h02);
    ex(16'h8235, 16'h0000, 16'h0002);
    mc(12'h415, 8'h04);
    br(6'h1e, 8'h10);
    ex(16'h9340, 16'h0abd, 16'h0002);
    mc(12'habd, 8'h80);
    ex(16'h95c8, 16'h0000, 16'h0003);
    br(6'h00, 8'hb1);
    ex(16'h9075, 16'h0000, 16'h0003);
    br(6'h07, 8'hb1);
    br(6'h1e, 8'h11);
    ex(16'h900c, 16'h0000, 16'h0002);
    br(6'h00, mv(16'h0201));
    br(6'h1a, 8'h01);
    ex(16'h935f, 16'h0000, 16'h0002);
    mc(12'hfff, 8'h80);
    br(`BTCIE_ADDR_SP_LO, 8'hfe);
    ex(16'h916f, 16'h0000, 16'h0002);
    br(6'h16, 8'h80);
    br(`BTCIE_ADDR_SP_LO, 8'hff);
    ex(16'h0000, 16'h0000, 16'h0001);
    check({12'h000, ev}, 16'h0000);
    ex(16'h9588, 16'h0000, 16'h0001);
    check({12'h000, ev}, 16'h0008);
    ex(16'h95a8, 16'h0000, 16'h0001);
    check({12'h000, ev}, 16'h0004);
    ex(16'h9598, 16'h0000, 16'h0000);
    check({12'h000, ev}, 16'h0002);
    br(`BTCIE_ADDR_STATUS, 8'h40);
    ex(16'h0c00, 16'h0000, 16'h0001);
    check({12'h000, ev}, 16'h0001);
    br(`BTCIE_ADDR_STATUS, 8'h40);
    final_report();
  end
endmodule
